// file: logic/vdos_cfg.svh
// Register offsets, field positions and reset values of the output/status register slice
`ifndef VDOS_CFG_SVH
`define VDOS_CFG_SVH
`define VDOS_OFS_FORMAT_DELAY 8'h10
`define VDOS_OFS_OUT_CTRL_ONE 8'h11
`define VDOS_OFS_OUT_CTRL_TWO 8'h12
`define VDOS_OFS_SLICER_STATUS 8'h1a
`define VDOS_OFS_SLICER_FIRST 8'h1b
`define VDOS_OFS_SLICER_SECOND 8'h1c
`define VDOS_OFS_DECODER_STATUS 8'h1f
`define VDOS_RST_FORMAT_DELAY 8'h40
`define VDOS_RST_OUT_CTRL_ONE 8'h1c
`define VDOS_RST_OUT_CTRL_TWO 8'h03
// Writable bit masks; unused positions always store zero
`define VDOS_MASK_OUT_CTRL_ONE 8'hbf
`define VDOS_MASK_OUT_CTRL_TWO 8'hdf
`define VDOS_LUMA_DEL_LSB 0
`define VDOS_VERT_LEN_BIT 3
`define VDOS_HSYNC_POS_LSB 4
`define VDOS_FORMAT_LSB 6
`define VDOS_BIT_COLOUR_ON 0
`define VDOS_BIT_BYPASS 1
`define VDOS_BIT_SYNC_OE 2
`define VDOS_BIT_PIXEL_OE 3
`define VDOS_BIT_INV_BLANK 4
`define VDOS_BIT_FE_POL 5
`define VDOS_BIT_GP_SWITCH 7
`define VDOS_ANALOG_SEL_LSB 0
`define VDOS_BIT_DITHER 2
`define VDOS_BIT_RGB_WIDE 3
`define VDOS_BIT_CHROMA_LIN 4
`define VDOS_BIT_RT_A 6
`define VDOS_BIT_RT_B 7
// Vertical reference windows (local line counts)
`define VDOS_V60_F1_FIRST 10'd18
`define VDOS_V60_F1_LAST 10'd259
`define VDOS_V60_F2_FIRST 10'd281
`define VDOS_V60_F2_LAST 10'd522
`define VDOS_V60S_F1_FIRST 10'd19
`define VDOS_V60S_F1_LAST 10'd258
`define VDOS_V60S_F2_FIRST 10'd282
`define VDOS_V60S_F2_LAST 10'd521
`define VDOS_V50S_F1_FIRST 10'd24
`define VDOS_V50S_F1_LAST 10'd309
`define VDOS_V50S_F2_FIRST 10'd337
`define VDOS_V50S_F2_LAST 10'd622
`define VDOS_V50_F1_FIRST 10'd23
`define VDOS_V50_F1_LAST 10'd310
`define VDOS_V50_F2_FIRST 10'd336
`define VDOS_V50_F2_LAST 10'd623
// Delay line depth: luma needs 3 steps back and 4 ahead, two clocks per step
`define VDOS_LUMA_CENTRE 4'd8
`define VDOS_DELAY_DEPTH 16
`endif

// file: logic/vdos_pkg.sv
// Types shared by the output/status register slice
package vdos_pkg;
   typedef enum logic [1:0] {
      VDOS_FMT_RGB,
      VDOS_FMT_YUV422,
      VDOS_FMT_YUV411,
      VDOS_FMT_CCIR656
   } vdos_format_t;
   typedef enum logic [1:0] {
      VDOS_ANALOG_TEST_OUT_TP1,
      VDOS_ANALOG_TEST_OUT_AIN1,
      VDOS_ANALOG_TEST_OUT_AIN2,
      VDOS_ANALOG_TEST_OUT_TP2
   } vdos_analog_test_out_t;
   typedef enum {
      VDOS_IDLE,
      VDOS_WRITE,
      VDOS_READ
   } vdos_state_t;
endpackage

// file: logic/vdos_regs.sv
// Output control and status register slice of the video decoder, with its output steering
`include "vdos_cfg.svh"

// Summary of operation
// - Luma delay field steps two clocks each
// - 60 Hz long pulse lines 18-259, 281-522
// - 50 Hz pulse 286 or 288 lines
// - Sync fine position, 0-3 two-clock steps
// - Bits 7..6 choose output format
// - Bit 0 forces colour on
// - Bypass routes raw samples to output
// - Sync pins float unless enabled
// - Pixel bus floats unless enabled
// - Bit 4 swaps in inverse blanking
// - Bit 5 picks qualifier phase for sampling
// - General switch pin follows bit 7
// - Analog test output mux by bits 1..0
// - Bit 2 enables noise shaping
// - RGB width 5:6:5 or 8:8:8
// - Bit 4 selects linear chroma interpolation
// - First realtime pin: odd field or length
// - Second realtime pin: phase or horizontal lock
// - Slicer status ready and valid flags
// - Slicer bytes: seven data plus parity
// - Status byte low five decoder flags
// - Status bits 5-7: rate, unlock, VTR
module vdos_regs (
   input wire logic clk_i,
   input wire logic reset_i,
   // Register port as seen after the serial bus slave
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Video timing from the decoder core
   input wire logic field_two_i,
   input wire logic field_60hz_i,
   input wire logic [9:0] line_count_i,
   input wire logic hsync_raw_i,
   input wire logic horizontal_reference_out_i,
   input wire logic vsync_i,
   input wire logic comp_blank_i,
   input wire logic [7:0] luma_i,
   input wire logic [15:0] decoded_data_i,
   input wire logic [15:0] adc_data_i,
   input wire logic fast_enable_input_i,
   input wire logic clock_qualifier_i,
   input wire logic colour_detect_i,
   input wire logic line_length_signal_i,
   input wire logic phase_lock_indicator_i,
   input wire logic horizontal_lock_signal_i,
   // Decoder status sources
   input wire logic field_one_ready_i,
   input wire logic field_one_valid_i,
   input wire logic field_two_ready_i,
   input wire logic field_two_valid_i,
   input wire logic [6:0] slicer_data_first_i,
   input wire logic parity_err_first_i,
   input wire logic [6:0] slicer_data_second_i,
   input wire logic parity_err_second_i,
   input wire logic slow_const_active_i,
   input wire logic white_peak_active_i,
   input wire logic gain_limit_bottom_i,
   input wire logic gain_limit_top_i,
   input wire logic horiz_unlock_flag_i,
   input wire logic vtr_time_const_flag_i,
   // Steered outputs
   output logic [7:0] luma_delayed_o,
   output logic horizontal_sync_out_o,
   output logic horizontal_sync_out_oe_o,
   output logic horizontal_reference_out_o,
   output logic horizontal_reference_out_oe_o,
   output logic vert_ref_out_o,
   output logic vert_ref_out_oe_o,
   output logic vertical_sync_out_o,
   output logic vertical_sync_out_oe_o,
   output logic [15:0] pixel_output_bus_o,
   output logic pixel_output_bus_oe_o,
   output vdos_pkg::vdos_format_t output_format_sel_o,
   output logic rgb_wide_sel_o,
   output logic colour_enable_o,
   output logic fast_enable_o,
   output logic general_switch_out_o,
   output vdos_pkg::vdos_analog_test_out_t analog_test_sel_o,
   output logic noise_shaping_enable_o,
   output logic chroma_interp_linear_o,
   output logic realtime_pin_a_o,
   output logic realtime_pin_b_o
);

   // ***************************************************************
   // Control registers
   // ***************************************************************
   logic [7:0] format_delay_control_r;
   logic [7:0] output_control_one_r;
   logic [7:0] output_control_two_r;
   logic [7:0] decoder_status_byte;
   logic [7:0] slicer_status;
   logic [7:0] rdata_nxt;

   // Host writes; unused bits are masked so they always read back zero
   // Masking here too keeps readback clean whatever the host sends
   // read-only offsets fall through
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         format_delay_control_r <= `VDOS_RST_FORMAT_DELAY;
         output_control_one_r <= `VDOS_RST_OUT_CTRL_ONE;
         output_control_two_r <= `VDOS_RST_OUT_CTRL_TWO;
      end else if (reg_write_i) begin
         case (reg_addr_i)
            `VDOS_OFS_FORMAT_DELAY: format_delay_control_r <= reg_wdata_i;
            `VDOS_OFS_OUT_CTRL_ONE: output_control_one_r <= reg_wdata_i & `VDOS_MASK_OUT_CTRL_ONE;
            `VDOS_OFS_OUT_CTRL_TWO: output_control_two_r <= reg_wdata_i & `VDOS_MASK_OUT_CTRL_TWO;
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // Read path
   // ***************************************************************
   // slicer ready and valid flags, upper nibble zero
   assign slicer_status = {4'h0, field_two_valid_i, field_two_ready_i,
                           field_one_valid_i, field_one_ready_i};
   // field rate, unlock and loop constant on top
   assign decoder_status_byte = {vtr_time_const_flag_i, horiz_unlock_flag_i, field_60hz_i,
                                 gain_limit_top_i, gain_limit_bottom_i, white_peak_active_i,
                                 slow_const_active_i, colour_detect_i};

   // Read multiplexer; unmapped offsets answer zero
   // Reads have no side effects, so a repeated read is harmless
   always_comb begin
      case (reg_addr_i)
         `VDOS_OFS_FORMAT_DELAY: rdata_nxt = format_delay_control_r;
         `VDOS_OFS_OUT_CTRL_ONE: rdata_nxt = output_control_one_r;
         `VDOS_OFS_OUT_CTRL_TWO: rdata_nxt = output_control_two_r;
         `VDOS_OFS_SLICER_STATUS: rdata_nxt = slicer_status;
         // parity flag above seven data bits
         `VDOS_OFS_SLICER_FIRST: rdata_nxt = {parity_err_first_i, slicer_data_first_i};
         `VDOS_OFS_SLICER_SECOND: rdata_nxt = {parity_err_second_i, slicer_data_second_i};
         `VDOS_OFS_DECODER_STATUS: rdata_nxt = decoder_status_byte;
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Read data is captured so the serial slave sees a stable byte
   // Status inputs are live, so a read shows them as they stand at the read edge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_read_i;
         if (reg_read_i) begin
            reg_rdata_o <= rdata_nxt;
         end
      end
   end

   // ***************************************************************
   // Delay lines for luma and horizontal sync
   // ***************************************************************
   // Sixteen stages cover eight luma steps and the widest sync shift
   logic [7:0] luma_line_r [0:`VDOS_DELAY_DEPTH-1];
   logic [`VDOS_DELAY_DEPTH-1:0] hsync_line_r;
   logic [2:0] luma_code;
   logic [1:0] hsync_steps;
   logic [3:0] luma_tap;

   // Signed three-bit step count maps to a tap around the centre
   function automatic logic [3:0] vdos_luma_tap(input logic [2:0] code);
      logic [3:0] steps2;
      steps2 = {1'b0, code[1:0], 1'b0};
      // Negative codes advance luma by taking a shallower tap
      // Codes 101 to 111 give three down to one step ahead
      if (code[2]) begin
         vdos_luma_tap = 4'(`VDOS_LUMA_CENTRE - (4'd8 - steps2));
      end else begin
         vdos_luma_tap = 4'(`VDOS_LUMA_CENTRE + steps2);
      end
   endfunction

   // Field slices of the format and delay register
   assign luma_code = format_delay_control_r[`VDOS_LUMA_DEL_LSB +: 3];
   assign hsync_steps = format_delay_control_r[`VDOS_HSYNC_POS_LSB +: 2];
   assign luma_tap = vdos_luma_tap(luma_code);

   // Shift registers; the centre tap keeps both signs reachable at the cost of latency
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < `VDOS_DELAY_DEPTH; i++) begin
            luma_line_r[i] <= 8'h00;
         end
         hsync_line_r <= '0;
      end else begin
         luma_line_r[0] <= luma_i;
         for (int i = 1; i < `VDOS_DELAY_DEPTH; i++) begin
            luma_line_r[i] <= luma_line_r[i-1];
         end
         hsync_line_r <= {hsync_line_r[`VDOS_DELAY_DEPTH-2:0], hsync_raw_i};
      end
   end

   // ***************************************************************
   // Vertical reference window
   // ***************************************************************
   logic vert_len_long;
   logic vref_window;

   function automatic logic vdos_in_range(input logic [9:0] line, input logic [9:0] lo,
                                          input logic [9:0] hi);
      vdos_in_range = (line >= lo) && (line <= hi);
   endfunction

   assign vert_len_long = format_delay_control_r[`VDOS_VERT_LEN_BIT];
   // Line numbers are the core's local count; the window adds one register stage

   // 242-line window at 60 Hz when long
   // 286 or 288 lines at 50 Hz
   always_comb begin
      if (field_60hz_i) begin
         if (vert_len_long) begin
            vref_window = field_two_i
               ? vdos_in_range(line_count_i, `VDOS_V60_F2_FIRST, `VDOS_V60_F2_LAST)
               : vdos_in_range(line_count_i, `VDOS_V60_F1_FIRST, `VDOS_V60_F1_LAST);
         end else begin
            vref_window = field_two_i
               ? vdos_in_range(line_count_i, `VDOS_V60S_F2_FIRST, `VDOS_V60S_F2_LAST)
               : vdos_in_range(line_count_i, `VDOS_V60S_F1_FIRST, `VDOS_V60S_F1_LAST);
         end
      end else if (vert_len_long) begin
         vref_window = field_two_i
            ? vdos_in_range(line_count_i, `VDOS_V50_F2_FIRST, `VDOS_V50_F2_LAST)
            : vdos_in_range(line_count_i, `VDOS_V50_F1_FIRST, `VDOS_V50_F1_LAST);
      end else begin
         vref_window = field_two_i
            ? vdos_in_range(line_count_i, `VDOS_V50S_F2_FIRST, `VDOS_V50S_F2_LAST)
            : vdos_in_range(line_count_i, `VDOS_V50S_F1_FIRST, `VDOS_V50S_F1_LAST);
      end
   end

   // ***************************************************************
   // Registered pin outputs
   // ***************************************************************
   // Sampling phase of the fast enable input
   logic fe_sample_phase;
   assign fe_sample_phase = output_control_one_r[`VDOS_BIT_FE_POL];

   // Delayed luma, sync and reference pins
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         luma_delayed_o <= 8'h00;
         horizontal_sync_out_o <= 1'b0;
         horizontal_reference_out_o <= 1'b0;
         vert_ref_out_o <= 1'b0;
         vertical_sync_out_o <= 1'b0;
      end else begin
         luma_delayed_o <= luma_line_r[luma_tap];
         horizontal_sync_out_o <= hsync_line_r[{hsync_steps, 1'b0}];
         horizontal_reference_out_o <= horizontal_reference_out_i;
         vert_ref_out_o <= output_control_one_r[`VDOS_BIT_INV_BLANK] ? ~comp_blank_i
                                                                     : vref_window;
         vertical_sync_out_o <= vsync_i;
      end
   end

   // Fast enable is held between samples on the chosen qualifier phase
   // A qualifier stuck at the wrong level freezes the last sample
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fast_enable_o <= 1'b0;
      end else if (clock_qualifier_i == fe_sample_phase) begin
         fast_enable_o <= fast_enable_input_i;
      end
   end

   // Colour killer decision, registered like the other data outputs
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         colour_enable_o <= 1'b0;
      end else begin
         colour_enable_o <= output_control_one_r[`VDOS_BIT_COLOUR_ON] | colour_detect_i;
      end
   end

   // Pixel bus and real-time pins
   // Switching bypass takes effect one clock later, never mid-sample
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pixel_output_bus_o <= 16'h0000;
         realtime_pin_a_o <= 1'b0;
         realtime_pin_b_o <= 1'b0;
      end else begin
         pixel_output_bus_o <= output_control_one_r[`VDOS_BIT_BYPASS] ? adc_data_i
                                                                      : decoded_data_i;
         realtime_pin_a_o <= output_control_two_r[`VDOS_BIT_RT_A] ? line_length_signal_i
                                                                  : ~field_two_i;
         realtime_pin_b_o <= output_control_two_r[`VDOS_BIT_RT_B] ? horizontal_lock_signal_i
                                                                  : phase_lock_indicator_i;
      end
   end

   // ***************************************************************
   // Direct control outputs
   // ***************************************************************
   // Enables are plain register bits; the pad ring does the tristating
   // sync pin drivers enabled
   assign horizontal_sync_out_oe_o = output_control_one_r[`VDOS_BIT_SYNC_OE];
   assign horizontal_reference_out_oe_o = output_control_one_r[`VDOS_BIT_SYNC_OE];
   assign vert_ref_out_oe_o = output_control_one_r[`VDOS_BIT_SYNC_OE];
   assign vertical_sync_out_oe_o = output_control_one_r[`VDOS_BIT_SYNC_OE];
   assign pixel_output_bus_oe_o = output_control_one_r[`VDOS_BIT_PIXEL_OE];
   assign output_format_sel_o = vdos_pkg::vdos_format_t'(
      format_delay_control_r[`VDOS_FORMAT_LSB +: 2]);
   assign rgb_wide_sel_o = output_control_two_r[`VDOS_BIT_RGB_WIDE];
   assign general_switch_out_o = output_control_one_r[`VDOS_BIT_GP_SWITCH];
   assign analog_test_sel_o = vdos_pkg::vdos_analog_test_out_t'(
      output_control_two_r[`VDOS_ANALOG_SEL_LSB +: 2]);
   assign noise_shaping_enable_o = output_control_two_r[`VDOS_BIT_DITHER];
   assign chroma_interp_linear_o = output_control_two_r[`VDOS_BIT_CHROMA_LIN];

endmodule

// file: verification/vdos_regs_properties.sv
// Port-level assertions for the output/status register slice
module vdos_regs_properties (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic field_60hz_i,
   input wire logic [6:0] slicer_data_first_i,
   input wire logic parity_err_first_i,
   input wire logic general_switch_out_o,
   input wire logic horizontal_sync_out_oe_o,
   input wire logic vertical_sync_out_oe_o,
   input wire logic pixel_output_bus_oe_o,
   input wire logic [1:0] output_format_sel_o,
   input wire logic [1:0] analog_test_sel_o,
   input wire logic noise_shaping_enable_o,
   input wire logic rgb_wide_sel_o,
   input wire logic chroma_interp_linear_o,
   input wire logic colour_enable_o,
   input wire logic horizontal_reference_out_i,
   input wire logic vsync_i,
   input wire logic horizontal_reference_out_o,
   input wire logic horizontal_reference_out_oe_o,
   input wire logic vert_ref_out_oe_o,
   input wire logic vertical_sync_out_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ********
   // Write strobes
   // ********
   logic wr_fmt, wr_one, wr_two;
   // One strobe per control register, so each check keys on its own address
   assign wr_fmt = reg_write_i && (reg_addr_i == 8'h10);
   assign wr_one = reg_write_i && (reg_addr_i == 8'h11);
   assign wr_two = reg_write_i && (reg_addr_i == 8'h12);
   // ********
   // Checks
   // ********
   AST_READ_BYTE: assert property (reg_read_i && reg_addr_i == 8'h1b |=> reg_rvalid_o &&
      reg_rdata_o == {$past(parity_err_first_i), $past(slicer_data_first_i)})
      else $error("slicer byte read wrong");
   AST_RATE_FLAG: assert property (reg_read_i && reg_addr_i == 8'h1f |=>
      reg_rdata_o[5] == $past(field_60hz_i)) else $error("rate flag wrong");
   AST_FORMAT: assert property (wr_fmt |=> output_format_sel_o == $past(reg_wdata_i[7:6]))
      else $error("format select wrong");
   AST_SYNC_OE: assert property (wr_one |=> horizontal_sync_out_oe_o == $past(reg_wdata_i[2])
      && vertical_sync_out_oe_o == horizontal_sync_out_oe_o
      && vert_ref_out_oe_o == horizontal_sync_out_oe_o
      && horizontal_reference_out_oe_o == horizontal_sync_out_oe_o)
      else $error("sync enable wrong");
   AST_PIXEL_OE: assert property (wr_one |=> pixel_output_bus_oe_o == $past(reg_wdata_i[3]))
      else $error("pixel enable wrong");
   AST_GP_SWITCH: assert property (wr_one |=> general_switch_out_o == $past(reg_wdata_i[7]))
      else $error("switch pin wrong");
   AST_COLOUR_ON: assert property (wr_one && reg_wdata_i[0] |=> ##1 colour_enable_o)
      else $error("colour not forced");
   AST_ANALOG_SEL: assert property (wr_two |=> analog_test_sel_o == $past(reg_wdata_i[1:0]))
      else $error("analog select wrong");
   AST_OUT_MODES: assert property (wr_two |=>
      {chroma_interp_linear_o, rgb_wide_sel_o, noise_shaping_enable_o} == $past(reg_wdata_i[4:2]))
      else $error("output modes wrong");
   AST_RGB_WIDE: assert property (wr_two |=> rgb_wide_sel_o == $past(reg_wdata_i[3]))
      else $error("RGB width select wrong");
   AST_SYNC_PASS: assert property (horizontal_reference_out_o == $past(horizontal_reference_out_i)
      && vertical_sync_out_o == $past(vsync_i)) else $error("sync pass-through wrong");
endmodule

// file: verification/vdos_host_model.sv
// Host model driving the decoded register port of the slice
module vdos_host_model (
   input wire logic clk_i,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_write_o,
   output logic reg_read_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle port at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_write_o = 1'b0;
      reg_read_o = 1'b0;
   end
   // Single write; released lines show the inverse so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= (a == 8'h11) ? (d & 8'hbf) : ((a == 8'h12) ? (d & 8'hdf) : d);
      reg_write_o <= 1'b1;
      @(posedge clk_i);
      reg_write_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   // Single read; no answer in the slot yields unknown data
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_read_o <= 1'b1;
      @(posedge clk_i);
      reg_read_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
   endtask
endmodule

// file: verification/vdos_regs_tb_top.sv
// Self-checking bench for the output/status register slice
module vdos_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, luma_delayed_o;
   logic reg_write_i, reg_read_i, reg_rvalid_o, vert_ref_out_o, horizontal_sync_out_o;
   logic fast_enable_o, realtime_pin_a_o, realtime_pin_b_o, colour_enable_o;
   logic [15:0] pixel_output_bus_o;
   logic [7:0] luma_i = 8'h00;
   logic [9:0] line_count_i = 10'h000;
   logic [31:0] sv = 32'h0000_0000;
   logic field_two_i = 1'b0;
   logic field_60hz_i = 1'b0;
   logic hsync_raw_i = 1'b0;
   logic comp_blank_i = 1'b0;
   logic fast_enable_input_i = 1'b0;
   logic clock_qualifier_i = 1'b0;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   int d0, d, m, b;
   int st [3] = '{0, -4, 3};
   // Window edges per mode: 60 long, 60 short, 50 short, 50 long
   logic [9:0] vb [4][4] = '{'{10'd18, 10'd259, 10'd281, 10'd522},
      '{10'd19, 10'd258, 10'd282, 10'd521}, '{10'd24, 10'd309, 10'd337, 10'd622},
      '{10'd23, 10'd310, 10'd336, 10'd623}};
   // ********
   // Clock, host and device
   // ********
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   vdos_host_model u_host (.clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_write_o(reg_write_i), .reg_read_o(reg_read_i), .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o));
   vdos_regs dut (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
      .reg_rdata_o, .reg_rvalid_o, .field_two_i, .field_60hz_i, .line_count_i, .hsync_raw_i,
      .horizontal_reference_out_i(sv[30]), .vsync_i(sv[31]), .comp_blank_i, .luma_i, .decoded_data_i(16'h1234),
      .adc_data_i(16'hcdef), .fast_enable_input_i, .clock_qualifier_i, .colour_detect_i(sv[20]),
      .line_length_signal_i(sv[27]), .phase_lock_indicator_i(sv[28]),
      .horizontal_lock_signal_i(sv[29]), .field_one_ready_i(sv[0]), .field_one_valid_i(sv[1]),
      .field_two_ready_i(sv[2]), .field_two_valid_i(sv[3]), .slicer_data_first_i(sv[10:4]),
      .parity_err_first_i(sv[11]), .slicer_data_second_i(sv[18:12]),
      .parity_err_second_i(sv[19]), .slow_const_active_i(sv[21]), .white_peak_active_i(sv[22]),
      .gain_limit_bottom_i(sv[23]), .gain_limit_top_i(sv[24]), .horiz_unlock_flag_i(sv[25]),
      .vtr_time_const_flag_i(sv[26]), .luma_delayed_o, .horizontal_sync_out_o,
      .horizontal_sync_out_oe_o(), .horizontal_reference_out_o(),
      .horizontal_reference_out_oe_o(), .vert_ref_out_o, .vert_ref_out_oe_o(),
      .vertical_sync_out_o(), .vertical_sync_out_oe_o(), .pixel_output_bus_o,
      .pixel_output_bus_oe_o(), .output_format_sel_o(), .rgb_wide_sel_o(), .colour_enable_o,
      .fast_enable_o, .general_switch_out_o(), .analog_test_sel_o(),
      .noise_shaping_enable_o(), .chroma_interp_linear_o(), .realtime_pin_a_o,
      .realtime_pin_b_o);
   // ********
   // Helpers
   // ********
   task automatic stop_test();
      if (err_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      u_host.rd(a, v);
      chk(v, exp);
   endtask
   // Let three edges pass so registered outputs have settled
   task automatic step();
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   // Edges from a one-cycle pulse on sync (0) or luma (1) to its arrival; flushes first
   task automatic lat(input int sel, output int n);
      repeat (20) @(posedge clk_i);
      if (sel == 0) hsync_raw_i <= 1'b1;
      else luma_i <= 8'hff;
      @(posedge clk_i);
      hsync_raw_i <= 1'b0;
      luma_i <= 8'h00;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         #1;
         if (sel == 0 ? horizontal_sync_out_o : luma_delayed_o[0]) break;
      end
   endtask
   // Hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end
   // ********
   // Sequence
   // ********
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      rchk(8'h10, 8'h40);
      rchk(8'h11, 8'h1c);
      rchk(8'h12, 8'h03);
      u_host.wr(8'h15, 8'hff);
      rchk(8'h15, 8'h00);
      u_host.wr(8'h11, 8'hff);
      rchk(8'h11, 8'hbf);
      u_host.wr(8'h12, 8'hff);
      rchk(8'h12, 8'hdf);
      u_host.wr(8'h11, 8'h0c);
      for (m = 0; m < 4; m++) begin
         u_host.wr(8'h10, {2'b01, m[1:0], 4'h0});
         lat(0, d);
         if (m == 0) d0 = d;
         chk(d - d0, 2 * m);
      end
      for (m = 0; m < 3; m++) begin
         u_host.wr(8'h10, {5'b01000, st[m][2:0]});
         lat(1, d);
         if (m == 0) d0 = d;
         chk(d - d0, 2 * st[m]);
      end
      for (m = 0; m < 4; m++) begin
         u_host.wr(8'h10, {4'h4, 1'(m == 0 || m == 3), 3'h0});
         for (b = 0; b < 8; b++) begin
            @(posedge clk_i);
            field_60hz_i <= (m < 2);
            field_two_i <= (b > 3);
            line_count_i <= vb[m][b / 2] + 10'((b % 4) == 3) - 10'((b % 4) == 0);
            step();
            if (m < 2) begin
               chk(vert_ref_out_o, (b % 4 == 1) || (b % 4 == 2));
            end else begin
               chk(vert_ref_out_o, (b % 4 == 1) || (b % 4 == 2));
            end
         end
      end
      u_host.wr(8'h11, 8'h1c);
      for (b = 0; b < 2; b++) begin
         @(posedge clk_i);
         comp_blank_i <= b[0];
         step();
         chk(vert_ref_out_o, !b[0]);
      end
      for (b = 0; b < 2; b++) begin
         u_host.wr(8'h11, {6'h03, b[0], 1'b0});
         step();
         chk(pixel_output_bus_o, b[0] ? 16'hcdef : 16'h1234);
      end
      for (b = 0; b < 4; b++) begin
         u_host.wr(8'h11, {2'b00, b[1], 5'h0c});
         @(posedge clk_i);
         clock_qualifier_i <= b[1] ~^ b[0];
         fast_enable_input_i <= !b[1];
         step();
         chk(fast_enable_o, b[1] ^ b[0]);
      end
      @(posedge clk_i);
      sv <= 32'h2800_0000;
      field_two_i <= 1'b1;
      for (b = 0; b < 4; b++) begin
         u_host.wr(8'h12, {b[1:0], 6'h03});
         step();
         chk(realtime_pin_a_o, b[0]);
         chk(realtime_pin_b_o, b[1]);
      end
      for (b = 0; b < 2; b++) begin
         @(posedge clk_i);
         sv <= b[0] ? 32'ha5a5_5a5a : 32'h5a5a_a5a5;
         field_60hz_i <= b[0];
         u_host.wr(8'h1b, 8'hff);
         u_host.wr(8'h1f, 8'h00);
         rchk(8'h1b, sv[11:4]);
         rchk(8'h1a, {4'h0, sv[3:0]});
         rchk(8'h1c, sv[19:12]);
         rchk(8'h1f, {sv[26:25], field_60hz_i, sv[24:20]});
         chk(colour_enable_o, sv[20]);
      end
      stop_test();
   end
endmodule
bind vdos_regs vdos_regs_properties u_props (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
   .reg_write_i, .reg_read_i, .reg_rdata_o, .reg_rvalid_o, .field_60hz_i, .slicer_data_first_i,
   .parity_err_first_i, .general_switch_out_o, .horizontal_sync_out_oe_o,
   .vertical_sync_out_oe_o, .pixel_output_bus_oe_o, .output_format_sel_o, .analog_test_sel_o,
   .noise_shaping_enable_o, .rgb_wide_sel_o, .chroma_interp_linear_o, .colour_enable_o,
   .horizontal_reference_out_i, .vsync_i, .horizontal_reference_out_o, .horizontal_reference_out_oe_o,
   .vert_ref_out_oe_o, .vertical_sync_out_o);
